// ### bench/pmc_ctrl_checker.sv
`timescale 1ns/1ns
module pmc_ctrl_checker #(
    parameter int N_SUB  = 8,
    parameter int N_WAKE = 6
) (
    input wire logic              pclk,        // clock
    input wire logic              presetn,     // async reset
    input wire logic              psel,        // apb select
    input wire logic              penable,     // apb enable
    input wire logic              pready,      // apb ready
    input wire logic [N_WAKE-1:0] wake_src,    // wakeup sources
    input wire logic [31:0]       pin_out,     // held pins
    input wire logic [N_SUB-1:0]  sub_clk_en,  // clock enables
    input wire logic [N_SUB-1:0]  sub_bias_en, // bias enables
    input wire pmc_pkg::pmc_clk_s clk_run,     // oscillators
    input wire pmc_pkg::pmc_reg_s reg_ctl,     // regulators
    input wire logic [3:0]        mode         // one-hot mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    // entry edge already holds pins; freeze is judged from the second hibernate cycle on
    sequence hib_twice;
        (mode == 4'h8) [*2];
    endsequence
    mode_onehot_a: assert property ($onehot(mode))
        else $error("mode not one-hot");
    ready_pulse_a: assert property (apb_setup |=> pready ##1 !pready)
        else $error("pready not a single access pulse");
    gate_bias_a: assert property (sub_clk_en == sub_bias_en)
        else $error("clock gate and bias disagree");
    sleep_gate_a: assert property ((mode[2] || mode[3]) |-> sub_clk_en == '0)
        else $error("subsystem running in low power");
    sleep_clk_a: assert property (mode == 4'h4 |-> clk_run == 3'b110 && reg_ctl.buzz)
        else $error("sleep clocks or buzz wrong");
    hib_off_a: assert property (mode == 4'h8 |-> clk_run == 3'b000 && reg_ctl == 4'b1000)
        else $error("hibernate clocks or regulators wrong");
    hib_freeze_a: assert property (hib_twice |-> $stable(pin_out))
        else $error("pins moved in hibernate");
    hib_wake_a: assert property (mode == 4'h8 && wake_src[1] |=> mode == 4'h1 && sub_clk_en[0])
        else $error("pin wake not taken");
    hib_hold_a: assert property (mode == 4'h8 && !wake_src[1] && !psel |=> mode == 4'h8)
        else $error("hibernate left without pin wake");
    sleep_wake_a: assert property (mode == 4'h4 && |wake_src |=> mode == 4'h1)
        else $error("sleep wake not taken");
endmodule : pmc_ctrl_checker
bind pmc_ctrl pmc_ctrl_checker #(.N_SUB(N_SUB), .N_WAKE(N_WAKE)) u_chk (.*);

// ### bench/tb.sv
`timescale 1ns/1ns
module tb;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]        paddr, sub_clk_en, sub_bias_en;
    logic [31:0]       pwdata, prdata, pin_out_in, pin_out, rd, v, p;
    logic [5:0]        wake_src;
    logic [3:0]        mode;
    pmc_pkg::pmc_clk_s clk_run;
    pmc_pkg::pmc_reg_s reg_ctl;
    integer            seed = 32'ha5ee;
    int                error_cnt, samples_checked;

    pmc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_src(wake_src), .pin_out_in(pin_out_in),
        .sub_clk_en(sub_clk_en), .sub_bias_en(sub_bias_en), .pin_out(pin_out),
        .clk_run(clk_run), .reg_ctl(reg_ctl), .mode(mode));

    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 0;
        penable <= 0;
        #1;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, a > 8'h14}, "slave error");
    endtask : rdchk

    // wake level is held across one sampling edge only
    task automatic wake(input logic [5:0] bits);
        @(posedge pclk);
        wake_src <= bits;
        @(posedge pclk);
        wake_src <= 0;
        #1;
    endtask : wake

    function automatic logic [31:0] mode_oh(input int req);
        return 32'h1 << req;
    endfunction : mode_oh

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        #40000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, wake_src, pin_out_in, presetn} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        #1;
        chk(mode, 1, "boot mode");
        chk(reg_ctl, 4'he, "boot regulators");
        rdchk(pmc_pkg::ADDR_STATUS, 32'h11);
        rdchk(pmc_pkg::ADDR_ACT_TMPL, 32'hff);
        rdchk(pmc_pkg::ADDR_ALT_TMPL, 32'hfe);
        rdchk(pmc_pkg::ADDR_REG_CTRL, 32'h3);
        rdchk(8'h20, 32'h0);
        $display("test reset done");
        repeat (8) begin
            v = $random(seed);
            apb(1, pmc_pkg::ADDR_ACT_TMPL, {24'h0, v[7:0]});
            chk(sub_clk_en, v[7:0], "template clocks");
        end
        apb(1, pmc_pkg::ADDR_ACT_TMPL, 32'hfe);
        chk(sub_clk_en, 8'hfe, "cpu off");
        wake(6'h08);
        chk(sub_clk_en, 8'hff, "cpu back");
        $display("test template done");
        for (int m = 1; m < 4; m++) begin
            v = $random(seed);
            apb(1, pmc_pkg::ADDR_ALT_TMPL, {24'h0, v[7:1], 1'b0});
            pin_out_in <= v;
            apb(1, pmc_pkg::ADDR_MODE_CTRL, m); // io supplies taken as valid from reset
            chk(mode, mode_oh(m), "mode entry");
            if (m == 1)
                chk(sub_clk_en, {v[7:1], 1'b0}, "alt clocks");
            if (m == 3) begin
                p = pin_out;
                pin_out_in <= ~v;
                wake(6'h3d);
                chk(mode, 8, "hibernate kept");
                chk(pin_out, p, "pins held");
            end
            wake(m == 3 ? 6'h02 : 6'h01 << (v[2:0] % 6));
            chk(mode, 1, "woken");
        end
        $display("test modes done");
        apb(1, pmc_pkg::ADDR_REG_CTRL, 0);
        chk(reg_ctl, 4'h8, "regulators off");
        $display("test regulators done");
        report_and_stop();
    end
endmodule : tb

// ### core/pmc_ctrl.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
// ----------------------------------------
// Overview of operation
// - four modes: active, alternate active, sleep, hibernate, in falling power.
// - in active each subsystem follows its own active template bit, except the cpu, which follows cpu_r.
// - template writes switch subsystems on or off while running.
// - disabled subsystem gets clock gated and analog bias removed.
// - cpu may disable itself; next wakeup re-enables it.
// - any wakeup returns mode to active and enables the cpu.
// - after boot the mode is active.
// - alternate active uses a reduced template, e.g. cpu and flash off.
// - sleep disables most resources regardless of templates.
// - sleep runs only low-speed and watch oscillators; regulators buzzed.
// - sleep exits on comparator, pin, i2c, rtc, timewheel or low-voltage wakeup.
// - hibernate stops all clocks; only pin interrupts wake it.
// - hibernate turns off all regulators but the hibernate regulator.
// - regulators enabled after power-up; firmware may disable them.
// - wakeup comes from an enabled interrupt or a device reset.
// - hibernate holds output pins and pin interrupt settings.
// ----------------------------------------
module pmc_ctrl #(
    parameter int N_SUB  = pmc_pkg::N_SUB,
    parameter int N_WAKE = pmc_pkg::N_WAKE
) (
    input  wire logic              pclk,        // apb clock
    input  wire logic              presetn,     // async reset, device reset wakeup
    input  wire logic              psel,        // apb select
    input  wire logic              penable,     // apb enable
    input  wire logic              pwrite,      // apb direction
    input  wire logic [7:0]        paddr,       // apb byte address
    input  wire logic [31:0]       pwdata,      // apb write data
    output logic      [31:0]       prdata,      // apb read data
    output logic                   pready,      // apb ready
    output logic                   pslverr,     // apb error
    input  wire logic [N_WAKE-1:0] wake_src,    // comparator,pin,i2c,rtc,timewheel,lvd
    input  wire logic [31:0]       pin_out_in,  // live digital pin outputs
    output logic      [N_SUB-1:0]  sub_clk_en,  // per-subsystem clock enable
    output logic      [N_SUB-1:0]  sub_bias_en, // per-subsystem analog bias enable
    output logic      [31:0]       pin_out,     // held pin outputs
    output pmc_pkg::pmc_clk_s      clk_run,     // oscillator run controls
    output pmc_pkg::pmc_reg_s      reg_ctl,     // regulator controls
    output logic      [3:0]        mode         // current mode, one-hot
);

    initial begin
        if (N_SUB < 2 || N_SUB > 32 || N_WAKE != pmc_pkg::N_WAKE)
            $error("pmc_ctrl: unsupported parameters");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    pmc_pkg::pmc_mode_e mode_r, mode_nxt;
    logic [N_SUB-1:0]  act_r, act_nxt, alt_r, alt_nxt;
    logic [N_WAKE-1:0] wen_r, wen_nxt;
    logic [1:0]        regc_r, regc_nxt;   // [0] digital, [1] analog
    logic              cpu_r, cpu_nxt;
    logic [31:0]       prdata_r, prdata_nxt;
    logic              pready_r, pready_nxt, perr_r, perr_nxt;
    logic [N_SUB-1:0]  en_nxt, clk_en_r, bias_en_r;
    logic [31:0]       pin_r, pin_nxt;
    pmc_pkg::pmc_clk_s clk_r, clk_nxt;
    pmc_pkg::pmc_reg_s regs_r, regs_nxt;
    logic              wake, wr, rd, hit;

    // ----------------------------------------
    // mode, templates, bus
    // ----------------------------------------
    always_comb begin
        mode_nxt   = mode_r;
        act_nxt    = act_r;
        alt_nxt    = alt_r;
        wen_nxt    = wen_r;
        regc_nxt   = regc_r;
        cpu_nxt    = cpu_r;
        prdata_nxt = prdata_r;
        // writes land only at the edge where the access phase sees pready high
        wr   = psel && penable && pwrite && pready_r;
        rd   = psel && !penable && !pwrite;
        hit  = 1'b1;
        pready_nxt = psel && !penable;
        perr_nxt   = 1'b0;
        // hibernate only hears the pin unit, others only their enables
        if (mode_r == pmc_pkg::PMC_HIBERNATE)
            wake = wake_src[pmc_pkg::WAKE_PIN_BIT] && wen_r[pmc_pkg::WAKE_PIN_BIT];
        else
            wake = |(wake_src & wen_r);
        unique case (paddr)
            pmc_pkg::ADDR_MODE_CTRL: ;
            pmc_pkg::ADDR_ACT_TMPL: ;
            pmc_pkg::ADDR_ALT_TMPL: ;
            pmc_pkg::ADDR_STATUS: ;
            pmc_pkg::ADDR_REG_CTRL: ;
            pmc_pkg::ADDR_WAKE_EN: ;
            default: hit = 1'b0;
        endcase
        if (rd) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                pmc_pkg::ADDR_MODE_CTRL: prdata_nxt[3:0] = mode_r;
                pmc_pkg::ADDR_ACT_TMPL:  prdata_nxt[N_SUB-1:0] = act_r;
                pmc_pkg::ADDR_ALT_TMPL:  prdata_nxt[N_SUB-1:0] = alt_r;
                pmc_pkg::ADDR_STATUS: begin
                    prdata_nxt[3:0] = mode_r;
                    prdata_nxt[pmc_pkg::ST_CPU_BIT] = cpu_r;
                end
                pmc_pkg::ADDR_REG_CTRL:  prdata_nxt[1:0] = regc_r;
                pmc_pkg::ADDR_WAKE_EN:   prdata_nxt[N_WAKE-1:0] = wen_r;
                default:                 prdata_nxt = 32'h0;
            endcase
        end
        if (psel && !penable && !hit)
            perr_nxt = 1'b1;
        if (wr) begin
            unique case (paddr)
                pmc_pkg::ADDR_MODE_CTRL: begin
                    unique case (pwdata[1:0])
                        pmc_pkg::MODE_REQ_ACTIVE: mode_nxt = pmc_pkg::PMC_ACTIVE;
                        pmc_pkg::MODE_REQ_ALT:    mode_nxt = pmc_pkg::PMC_ALTACTIVE;
                        pmc_pkg::MODE_REQ_SLEEP:  mode_nxt = pmc_pkg::PMC_SLEEP;
                        default:                  mode_nxt = pmc_pkg::PMC_HIBERNATE;
                    endcase
                end
                pmc_pkg::ADDR_ACT_TMPL: begin
                    act_nxt = pwdata[N_SUB-1:0];
                    cpu_nxt = pwdata[pmc_pkg::CPU_BIT];
                end
                pmc_pkg::ADDR_ALT_TMPL:  alt_nxt  = pwdata[N_SUB-1:0];
                pmc_pkg::ADDR_REG_CTRL:  regc_nxt = pwdata[1:0];
                pmc_pkg::ADDR_WAKE_EN:   wen_nxt  = pwdata[N_WAKE-1:0];
                default: ;
            endcase
        end
        // wakeup beats a same-cycle mode write or cpu bit write; other writes still land
        if (wake) begin
            mode_nxt = pmc_pkg::PMC_ACTIVE;
            cpu_nxt  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r   <= pmc_pkg::PMC_ACTIVE;
            act_r    <= N_SUB'(pmc_pkg::ACT_TMPL_RST);
            alt_r    <= N_SUB'(pmc_pkg::ALT_TMPL_RST);
            wen_r    <= pmc_pkg::WAKE_EN_RST;
            regc_r   <= 2'h3;
            cpu_r    <= 1'b1;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            perr_r   <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            act_r    <= act_nxt;
            alt_r    <= alt_nxt;
            wen_r    <= wen_nxt;
            regc_r   <= regc_nxt;
            cpu_r    <= cpu_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            perr_r   <= perr_nxt;
        end
    end

    // ----------------------------------------
    // gating, clocks, regulators, pin hold
    // ----------------------------------------
    always_comb begin
        en_nxt   = '0;
        pin_nxt  = pin_in_hold(mode_nxt, pin_r, pin_out_in);
        clk_nxt  = '0;
        regs_nxt = '0;
        unique case (mode_nxt)
            pmc_pkg::PMC_ACTIVE: begin
                en_nxt = act_nxt;
                en_nxt[pmc_pkg::CPU_BIT] = cpu_nxt;
                clk_nxt  = '{lowspeed_osc_run: 1'b1, watch_osc_run: 1'b1, fast_clk_run: 1'b1};
                regs_nxt = '{hib_on: 1'b1, dig_on: regc_nxt[0], ana_on: regc_nxt[1], buzz: 1'b0};
            end
            pmc_pkg::PMC_ALTACTIVE: begin
                en_nxt = alt_nxt;
                clk_nxt  = '{lowspeed_osc_run: 1'b1, watch_osc_run: 1'b1, fast_clk_run: 1'b1};
                regs_nxt = '{hib_on: 1'b1, dig_on: regc_nxt[0], ana_on: regc_nxt[1], buzz: 1'b0};
            end
            pmc_pkg::PMC_SLEEP: begin
                en_nxt   = '0;
                clk_nxt  = '{lowspeed_osc_run: 1'b1, watch_osc_run: 1'b1, fast_clk_run: 1'b0};
                regs_nxt = '{hib_on: 1'b1, dig_on: regc_nxt[0], ana_on: regc_nxt[1], buzz: 1'b1};
            end
            pmc_pkg::PMC_HIBERNATE: begin
                en_nxt   = '0;
                clk_nxt  = '0;
                regs_nxt = '{hib_on: 1'b1, dig_on: 1'b0, ana_on: 1'b0, buzz: 1'b0};
            end
        endcase
    end

    // outputs freeze on entry to hibernate, follow live values otherwise
    function automatic logic [31:0] pin_in_hold(input pmc_pkg::pmc_mode_e m,
                                                input logic [31:0] held,
                                                input logic [31:0] live);
        pin_in_hold = (m == pmc_pkg::PMC_HIBERNATE) ? held : live;
    endfunction : pin_in_hold

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en_r  <= '1;
            bias_en_r <= '1;
            pin_r     <= 32'h0;
            clk_r     <= '{lowspeed_osc_run: 1'b1, watch_osc_run: 1'b1, fast_clk_run: 1'b1};
            regs_r    <= '{hib_on: 1'b1, dig_on: 1'b1, ana_on: 1'b1, buzz: 1'b0};
        end else begin
            clk_en_r  <= en_nxt;
            bias_en_r <= en_nxt;
            pin_r     <= pin_nxt;
            clk_r     <= clk_nxt;
            regs_r    <= regs_nxt;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = perr_r;
    assign sub_clk_en  = clk_en_r;
    assign sub_bias_en = bias_en_r;
    assign pin_out     = pin_r;
    assign clk_run     = clk_r;
    assign reg_ctl     = regs_r;
    assign mode        = mode_r;

endmodule : pmc_ctrl

// ### core/pmc_pkg.sv
package pmc_pkg;

    // ----------------------------------------
    // power modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        PMC_ACTIVE    = 4'h1,
        PMC_ALTACTIVE = 4'h2,
        PMC_SLEEP     = 4'h4,
        PMC_HIBERNATE = 4'h8
    } pmc_mode_e;

    localparam logic [1:0] MODE_REQ_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_REQ_ALT    = 2'h1;
    localparam logic [1:0] MODE_REQ_SLEEP  = 2'h2;
    localparam logic [1:0] MODE_REQ_HIB    = 2'h3;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACT_TMPL  = 8'h04;
    localparam logic [7:0] ADDR_ALT_TMPL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0c;
    localparam logic [7:0] ADDR_REG_CTRL  = 8'h10;
    localparam logic [7:0] ADDR_WAKE_EN   = 8'h14;

    localparam int N_SUB         = 8;
    localparam int CPU_BIT       = 0;
    localparam int N_WAKE        = 6;

    localparam logic [N_SUB-1:0]  ACT_TMPL_RST = 8'hff;
    localparam logic [N_SUB-1:0]  ALT_TMPL_RST = 8'hfe;
    localparam logic [N_WAKE-1:0] WAKE_EN_RST  = 6'h3f;
    localparam int                WAKE_PIN_BIT = 1;

    // status layout: [3:0] mode, [4] cpu enabled
    localparam int ST_CPU_BIT = 4;

    // regulator enables
    typedef struct packed {
        logic hib_on;
        logic dig_on;
        logic ana_on;
        logic buzz;
    } pmc_reg_s;

    typedef struct packed {
        logic                  lowspeed_osc_run;
        logic                  watch_osc_run;
        logic                  fast_clk_run;
    } pmc_clk_s;

endpackage : pmc_pkg
